// [core/level_ctrl_params.svh]
// offsets, field codes and reset values of the priority level controller
`ifndef LEVEL_CTRL_PARAMS_SVH
`define LEVEL_CTRL_PARAMS_SVH
// instruction fields, bit 0 is the word msb
`define LC_OP_CTRL    6'h3f
`define LC_AUG_EI     3'h0
`define LC_AUG_DI     3'h1
`define LC_AUG_RI     3'h2
`define LC_AUG_AI     3'h3
`define LC_AUG_DAI    3'h4
`define LC_AUG_CHAN   3'h7
`define LC_HW_BEI     16'h0006
`define LC_HW_UEI     16'h0007
`define LC_SUB_ECI    4'hc
`define LC_SUB_DCI    4'hd
`define LC_SUB_ACI    4'he
`define LC_SUB_CHANNEL_DEACTIVATE_CMD   4'hf
// level map
`define LC_TRAP_LO    7'h02
`define LC_TRAP_HI    7'h11
`define LC_CHAN_LO    7'h14
`define LC_CHAN_HI    7'h23
`define LC_REAL_TIME_OPTION_MODULE_LVL   7'h28
// condition codes
`define LC_CC_INOP    4'h2
`define LC_CC_UNSUP   4'h5
// register byte offsets
`define LC_REG_CLASS  4'h0
`define LC_REG_SEL    4'h4
`define LC_REG_STATE  4'h8
`define LC_REG_STATUS 4'hc
// reset values
`define LC_RST_CLASS  16'h0000
`define LC_RST_SEL    7'h00
`define LC_RST_LEVELS 128'h0
`endif

// [core/level_ctrl_pkg.sv]
// types shared by the priority level controller and its bench
package level_ctrl_pkg;
    typedef enum logic [1:0] {
        TRAP_NONE, TRAP_PRIV, TRAP_UNDEF, TRAP_SYSCHK
    } trap_kind_t;
    typedef enum logic {ST_IDLE, ST_CHAN_WAIT} state_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] word;
        logic [31:0] gpr;
    } instr_req_t;
    typedef struct packed {
        logic       done;
        logic       cc_set;
        logic [3:0] cc;
        trap_kind_t trap;
    } instr_res_t;
    typedef struct packed {
        logic        valid;
        logic [3:0]  op;
        logic [15:0] addr;
    } chan_cmd_t;
    typedef struct packed {
        logic       valid;
        logic [3:0] cc;
        logic       fault;
    } chan_rsp_t;
endpackage

// [core/level_ctrl.sv]
// priority interrupt level state, channel commands and sense blocking
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`include "level_ctrl_params.svh"
module level_ctrl (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // avalon slave
    input  wire logic [3:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    // execution unit
    input  wire level_ctrl_pkg::instr_req_t instr,
    input  wire logic                       privileged,
    input  wire logic                       doubleword_status_mode,
    output level_ctrl_pkg::instr_res_t      result,
    output logic                            busy,
    // grant
    output logic                            irq_req,
    output logic [6:0]                      irq_level,
    input  wire logic                       irq_take,
    // request sources and strap pin
    input  wire logic [127:0]               src_req,
    input  wire logic                       strap_const_enable,
    // channels
    output level_ctrl_pkg::chan_cmd_t       chan_cmd,
    input  wire level_ctrl_pkg::chan_rsp_t  chan_rsp,
    output logic                            sense_blocked
);
    import level_ctrl_pkg::*;

    state_t       st;
    logic [127:0] request;
    logic [127:0] enable;
    logic [127:0] active;
    logic [15:0]  class_f;
    logic [6:0]   sel;
    logic         hold_pair;
    logic         channel_deactivate_cmd_q;
    logic         strap_s1;
    logic         strap_s2;
    logic         strap_s3;
    logic         strap_q;

    // instruction fields
    logic [5:0]   f_op;
    logic [6:0]   f_lvl;
    logic [2:0]   f_aug;
    logic [2:0]   f_reg;
    logic [3:0]   f_sub;
    logic [15:0]  f_const;
    logic [15:0]  ch_addr;
    logic         accept;
    logic         is_lvl;
    logic         is_chan;
    logic         is_bei;
    logic         is_uei;
    logic         lvl_trap;
    logic         lvl_cls_f;
    logic         lvl_do;
    logic         ch_cls_f;

    assign f_op    = instr.word[31:26];
    assign f_lvl   = instr.word[25:19];
    assign f_aug   = instr.word[18:16];
    assign f_reg   = instr.word[25:23];
    assign f_sub   = instr.word[22:19];
    assign f_const = instr.word[15:0];
    assign accept  = instr.valid && (st == ST_IDLE);

    // decode
    assign is_lvl   = (f_op == `LC_OP_CTRL) && (f_aug <= `LC_AUG_DAI);
    assign is_chan  = (f_op == `LC_OP_CTRL) && (f_aug == `LC_AUG_CHAN)
                      && (f_sub >= `LC_SUB_ECI);
    assign is_bei   = instr.word[31:16] == `LC_HW_BEI;
    assign is_uei   = instr.word[31:16] == `LC_HW_UEI;
    assign lvl_trap = (f_lvl >= `LC_TRAP_LO) && (f_lvl <= `LC_TRAP_HI);
    assign lvl_cls_f = (f_lvl >= `LC_CHAN_LO) && (f_lvl <= `LC_CHAN_HI)
                       && class_f[4'(f_lvl - `LC_CHAN_LO)];
    // level ops act only when privileged and outside trap levels and class_f channel levels
    assign lvl_do = accept && is_lvl && privileged
                    && !lvl_trap && !lvl_cls_f;
    // logical channel and subaddress
    assign ch_addr  = f_const + ((f_reg != 3'h0) ? instr.gpr[15:0] : 16'h0000);
    assign ch_cls_f = (ch_addr[15:12] == 4'h0) && class_f[ch_addr[11:8]];

    // strap pin sync, taken once second and third stages agree
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            strap_s3 <= 1'b0;
            strap_q  <= 1'b0;
        end else begin
            strap_s1 <= strap_const_enable;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            if (strap_s2 == strap_s3) begin
                strap_q <= strap_s3;
            end
        end
    end

    // effective enable and sensed source requests
    logic [127:0] en_eff;
    logic [127:0] ext_src;
    logic [127:0] sensed;
    always_comb begin
        en_eff  = enable;
        ext_src = 128'h0;
        if (strap_q) begin
            en_eff[1:0] = 2'h3;
        end
        ext_src[35:20] = 16'hffff;
        ext_src[1:0]   = 2'h3;
        ext_src[40]    = 1'b1;
        sensed = src_req & en_eff & ~(sense_blocked ? ext_src : 128'h0);
        sensed[17:2] = 16'h0000;
    end

    // next level state
    logic [127:0] next_request;
    logic [127:0] next_enable;
    logic [127:0] next_active;
    always_comb begin
        next_request = request;
        next_enable  = enable;
        next_active  = active;
        if (irq_take && irq_req) begin
            next_request[irq_level] = 1'b0;
            next_active[irq_level]  = 1'b1;
        end
        if (lvl_do) begin
            case (f_aug)
                `LC_AUG_EI: next_enable[f_lvl] = 1'b1;
                `LC_AUG_DI: begin
                    next_enable[f_lvl]  = 1'b0;
                    next_request[f_lvl] = 1'b0;
                end
                `LC_AUG_AI:  next_active[f_lvl] = 1'b1;
                `LC_AUG_DAI: next_active[f_lvl] = 1'b0;
                default: ;
            endcase
        end
        // sets win over clears; blocked levels do not latch
        next_request = next_request | sensed;
        if (lvl_do && (f_aug == `LC_AUG_RI)) begin
            next_request[f_lvl] = 1'b1;
        end
    end

    // level state registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            request <= `LC_RST_LEVELS;
            enable  <= `LC_RST_LEVELS;
            active  <= `LC_RST_LEVELS;
        end else begin
            request <= next_request;
            enable  <= next_enable;
            active  <= next_active;
        end
    end

    // priority search, stops at the first active level
    logic       found;
    logic       stop;
    logic [6:0] g_lvl;
    logic [7:0] first_act;
    always_comb begin
        found     = 1'b0;
        stop      = 1'b0;
        g_lvl     = 7'h00;
        first_act = 8'h80;
        for (int i = 0; i < 128; i++) begin
            if (!found && !stop) begin
                if (active[i]) begin
                    stop      = 1'b1;
                    first_act = 8'(i);
                end else if (request[i] && en_eff[i]) begin
                    found = 1'b1;
                    g_lvl = 7'(i);
                end
            end
        end
    end

    // grant output, held off across a deactivate pair
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_req   <= 1'b0;
            irq_level <= 7'h00;
        end else begin
            irq_req   <= found && !hold_pair && !irq_take;
            irq_level <= g_lvl;
        end
    end

    // uninterruptible pair after deactivate in doubleword mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_pair <= 1'b0;
        end else if (accept) begin
            hold_pair <= doubleword_status_mode && (
                         (is_lvl && privileged && f_aug == `LC_AUG_DAI)
                         || (is_chan && f_sub == `LC_SUB_CHANNEL_DEACTIVATE_CMD));
        end
    end

    // block and unblock of external sensing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sense_blocked <= 1'b0;
        end else if (accept && is_bei) begin
            sense_blocked <= 1'b1;
        end else if (accept && is_uei) begin
            sense_blocked <= 1'b0;
        end
    end

    // instruction sequencing, channel command and result
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st       <= ST_IDLE;
            channel_deactivate_cmd_q   <= 1'b0;
            chan_cmd <= '0;
            result   <= '0;
            busy     <= 1'b0;
        end else begin
            chan_cmd.valid <= 1'b0;
            result         <= '0;
            case (st)
                ST_IDLE: begin
                    if (accept && is_chan && !ch_cls_f) begin
                        result.done <= 1'b1;
                        result.trap <= TRAP_UNDEF;
                    end else if (accept && is_chan) begin
                        chan_cmd.valid <= 1'b1;
                        chan_cmd.op    <= f_sub;
                        chan_cmd.addr  <= ch_addr;
                        channel_deactivate_cmd_q         <= f_sub == `LC_SUB_CHANNEL_DEACTIVATE_CMD;
                        busy           <= 1'b1;
                        st             <= ST_CHAN_WAIT;
                    end else if (accept && is_lvl && !privileged) begin
                        result.done <= 1'b1;
                        result.trap <= TRAP_PRIV;
                    end else if (accept) begin
                        result.done <= 1'b1;
                    end
                end
                ST_CHAN_WAIT: begin
                    if (chan_rsp.valid) begin
                        result.done   <= 1'b1;
                        result.cc_set <= 1'b1;
                        result.cc     <= chan_rsp.cc;
                        if (channel_deactivate_cmd_q && chan_rsp.fault
                            && chan_rsp.cc != `LC_CC_INOP) begin
                            result.trap <= TRAP_SYSCHK;
                        end
                        busy <= 1'b0;
                        st   <= ST_IDLE;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // avalon slave, one wait cycle per access
    logic        acc;
    logic [31:0] rd;
    assign acc = (avs_read || avs_write) && avs_waitrequest;
    always_comb begin
        case (avs_address)
            `LC_REG_CLASS: rd = {16'h0000, class_f};
            `LC_REG_SEL:   rd = {25'h0, sel};
            `LC_REG_STATE: rd = {28'h0, en_eff[sel], active[sel],
                                 enable[sel], request[sel]};
            `LC_REG_STATUS: rd = {20'h0, irq_req, irq_level, strap_q,
                                  hold_pair, sense_blocked, busy};
            default:       rd = 32'h0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= !acc;
            if (acc && avs_read) begin
                avs_readdata <= rd;
            end
        end
    end

    // software registers written on the completing edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            class_f <= `LC_RST_CLASS;
            sel     <= `LC_RST_SEL;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == `LC_REG_CLASS) begin
                class_f <= avs_writedata[15:0];
            end
            if (avs_address == `LC_REG_SEL) begin
                sel <= avs_writedata[6:0];
            end
        end
    end

    // addressed level's active bit, kept for the disable check
    logic lvl_act;
    assign lvl_act = active[f_lvl];

    // checks
    sequence s_chan_issue;
        accept && is_chan && ch_cls_f;
    endsequence
    sequence s_chan_cmd;
        chan_cmd.valid && busy;
    endsequence

    a_priv_trap: assert property (@(posedge clock) disable iff (rst)
        accept && is_lvl && !privileged
        |=> result.done && result.trap == TRAP_PRIV && $stable(active)
            && $stable(enable))
        else $error("unprivileged level op not trapped");
    a_req_latch: assert property (@(posedge clock) disable iff (rst)
        lvl_do && f_aug == `LC_AUG_RI |=> request[$past(f_lvl)])
        else $error("request level not latched");
    a_trap_levels: assert property (@(posedge clock) disable iff (rst)
        request[17:2] == 16'h0000 && active[17:2] == 16'h0000)
        else $error("trap level state touched");
    a_act_set: assert property (@(posedge clock) disable iff (rst)
        lvl_do && f_aug == `LC_AUG_AI |=> active[$past(f_lvl)])
        else $error("activate did not set active");
    a_dis_clear: assert property (@(posedge clock) disable iff (rst)
        lvl_do && f_aug == `LC_AUG_DI
        |=> !enable[$past(f_lvl)]
            && active[$past(f_lvl)] == $past(lvl_act))
        else $error("disable wrong");
    a_deact_clear: assert property (@(posedge clock) disable iff (rst)
        lvl_do && f_aug == `LC_AUG_DAI |=> !active[$past(f_lvl)])
        else $error("deactivate did not clear active");
    a_grant_block: assert property (@(posedge clock) disable iff (rst)
        irq_req |-> 8'(irq_level) < $past(first_act))
        else $error("grant at or below an active level");
    a_pair_hold: assert property (@(posedge clock) disable iff (rst)
        hold_pair |=> !irq_req)
        else $error("grant inside deactivate pair");
    a_chan_order: assert property (@(posedge clock) disable iff (rst)
        s_chan_issue |=> s_chan_cmd ##0 chan_cmd.op == $past(f_sub))
        else $error("channel command not issued");
    a_chan_cc: assert property (@(posedge clock) disable iff (rst)
        st == ST_CHAN_WAIT && chan_rsp.valid
        |=> result.done && result.cc_set && result.cc == $past(chan_rsp.cc)
            && !busy)
        else $error("channel condition code not returned");
    a_undef_trap: assert property (@(posedge clock) disable iff (rst)
        accept && is_chan && !ch_cls_f
        |=> result.trap == TRAP_UNDEF && !chan_cmd.valid)
        else $error("undefined channel not trapped");
    a_block_sense: assert property (@(posedge clock) disable iff (rst)
        accept && is_bei |=> sense_blocked)
        else $error("block did not set");
endmodule // level_ctrl

// [verification/chan_partner.sv]
// channel processor model that answers channel commands
`timescale 1ns/100ps
module chan_partner (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // command and answer
    input  wire level_ctrl_pkg::chan_cmd_t chan_cmd,
    output level_ctrl_pkg::chan_rsp_t      chan_rsp,
    // answer shape and queued requests
    input  wire logic [3:0]                rsp_cc,
    input  wire logic                      rsp_fault,
    input  wire logic [3:0]                rsp_wait,
    input  wire logic [15:0]               chan_pend,
    output logic [15:0]                    chan_req
);
    import level_ctrl_pkg::*;
    logic [15:0] enabled;
    logic [15:0] contend;
    logic [4:0]  count;
    // channel enable and contention state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enabled <= 16'h0000;
            contend <= 16'h0000;
        end else if (chan_cmd.valid) begin
            case (chan_cmd.op)
                4'hc: enabled[chan_cmd.addr[11:8]] <= 1'b1;
                4'hd: enabled[chan_cmd.addr[11:8]] <= 1'b0;
                4'he: contend[chan_cmd.addr[11:8]] <= 1'b1;
                default: contend[chan_cmd.addr[11:8]] <= 1'b0;
            endcase
        end
    end
    // queued request shows only while enabled and out of contention
    assign chan_req = chan_pend & enabled & ~contend;
    // answer after rsp_wait+1 idle cycles, idle fields toggle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count    <= 5'h00;
            chan_rsp <= '0;
        end else if (chan_cmd.valid) begin
            count          <= {1'b0, rsp_wait} + 5'h01;
            chan_rsp.valid <= 1'b0;
        end else if (count == 5'h01) begin
            count    <= 5'h00;
            chan_rsp <= '{valid: 1'b1, cc: rsp_cc, fault: rsp_fault};
        end else begin
            count    <= (count == 5'h00) ? count : count - 5'h01;
            chan_rsp <= '{valid: 1'b0, cc: ~chan_rsp.cc, fault: ~chan_rsp.fault};
        end
    end
endmodule // chan_partner

// [verification/level_ctrl_tb.sv]
// self-checking bench for the priority level controller
`timescale 1ns/100ps
`include "level_ctrl_params.svh"
module level_ctrl_tb;
    import level_ctrl_pkg::*;
    typedef struct packed {
        logic [2:0] aug;
        logic [6:0] lvl;
        logic       priv;
        logic [3:0] st;
        trap_kind_t trap;
    } row_t;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    logic [3:0]   avs_address = 4'h0;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    instr_req_t   instr = '0;
    logic         privileged = 1'b0;
    logic         doubleword_status_mode = 1'b0;
    instr_res_t   result;
    instr_res_t   res;
    logic         busy;
    logic         irq_req;
    logic [6:0]   irq_level;
    logic         irq_take = 1'b0;
    logic [127:0] src = '0;
    logic [127:0] src_req;
    logic         strap_const_enable = 1'b0;
    chan_cmd_t    chan_cmd;
    chan_cmd_t    last_cmd;
    logic         cmd_busy;
    chan_rsp_t    chan_rsp;
    logic         sense_blocked;
    logic [3:0]   rsp_cc = 4'h0;
    logic         rsp_fault = 1'b0;
    logic [3:0]   rsp_wait = 4'h0;
    logic [15:0]  chan_req;
    int           ncmd = 0;
    int           errors = 0;
    int           checked = 0;
    row_t         rows [16];
    level_ctrl u_dut (
        .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .instr, .privileged, .doubleword_status_mode,
        .result, .busy, .irq_req, .irq_level, .irq_take, .src_req, .strap_const_enable,
        .chan_cmd, .chan_rsp, .sense_blocked
    );
    chan_partner u_chan (
        .clock, .rst, .chan_cmd, .chan_rsp, .rsp_cc, .rsp_fault, .rsp_wait,
        .chan_pend(16'h0002), .chan_req
    );
    // channel requests land on the channel levels
    assign src_req = src | ({112'h0, chan_req} << `LC_CHAN_LO);
    // clock
    always #12.5 clock = ~clock;
    // capture every channel command
    always @(posedge clock) begin
        if (chan_cmd.valid === 1'b1) begin
            last_cmd <= chan_cmd;
            cmd_busy <= busy;
            ncmd     <= ncmd + 1;
        end
    end
    task automatic conclude();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic timeout();
        errors++;
        conclude();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= ~wr;
        avs_write     <= wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) timeout();
    endtask
    // one instruction, waits for its done pulse
    task automatic exec(input logic [31:0] w, input logic [31:0] g, input logic p);
        int n;
        n = 0;
        @(posedge clock);
        instr      <= '{valid: 1'b1, word: w, gpr: g};
        privileged <= p;
        do begin
            @(posedge clock);
            instr.valid <= 1'b0;
            #1;
            n++;
        end while (result.done !== 1'b1 && n < 100);
        res = result;
        if (n >= 100) timeout();
    endtask
    task automatic chk_st(input logic [6:0] l, input logic [3:0] e);
        logic [31:0] q;
        av(1'b1, `LC_REG_SEL, {25'h0, l}, q);
        av(1'b0, `LC_REG_STATE, 32'h0, q);
        check(q, {28'h0, e});
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (irq_req !== 1'b1 && n < 50);
        if (n >= 50) timeout();
    endtask
    task automatic pulse(input logic [127:0] m);
        @(posedge clock);
        src <= m;
        repeat (2) @(posedge clock);
        src <= '0;
    endtask
    function automatic logic [31:0] lw(input logic [2:0] a, input logic [6:0] l);
        return {`LC_OP_CTRL, l, a, 16'h0000};
    endfunction
    // main sequence
    initial begin
        logic [31:0] q;
        rows = '{
            '{`LC_AUG_RI, 7'h30, 1'b1, 4'h1, TRAP_NONE},
            '{`LC_AUG_AI, 7'h30, 1'b1, 4'h5, TRAP_NONE},
            '{`LC_AUG_DAI, 7'h30, 1'b1, 4'h1, TRAP_NONE},
            '{`LC_AUG_AI, 7'h30, 1'b0, 4'h1, TRAP_PRIV},
            '{`LC_AUG_RI, 7'h31, 1'b0, 4'h0, TRAP_PRIV},
            '{`LC_AUG_EI, 7'h30, 1'b1, 4'hb, TRAP_NONE},
            '{`LC_AUG_AI, 7'h30, 1'b1, 4'hf, TRAP_NONE},
            '{`LC_AUG_DI, 7'h30, 1'b0, 4'hf, TRAP_PRIV},
            '{`LC_AUG_DI, 7'h30, 1'b1, 4'h4, TRAP_NONE},
            '{`LC_AUG_DAI, 7'h30, 1'b1, 4'h0, TRAP_NONE},
            '{`LC_AUG_RI, 7'h05, 1'b1, 4'h0, TRAP_NONE},
            '{`LC_AUG_RI, 7'h11, 1'b1, 4'h0, TRAP_NONE},
            '{`LC_AUG_AI, 7'h02, 1'b1, 4'h0, TRAP_NONE},
            '{`LC_AUG_RI, 7'h12, 1'b1, 4'h1, TRAP_NONE},
            '{`LC_AUG_RI, 7'h14, 1'b1, 4'h0, TRAP_NONE},
            '{`LC_AUG_AI, 7'h14, 1'b1, 4'h0, TRAP_NONE}
        };
        repeat (12) @(posedge clock);
        check({27'h0, avs_waitrequest, irq_req, busy, sense_blocked, result.done}, 32'h10);
        rst <= 1'b0;
        av(1'b0, `LC_REG_CLASS, 32'h0, q);
        check(q, {16'h0, `LC_RST_CLASS});
        av(1'b1, 4'h2, 32'hffff_ffff, q);
        av(1'b0, 4'h2, 32'h0, q);
        check(q, 32'h0);
        av(1'b1, `LC_REG_CLASS, 32'h0000_0003, q);
        foreach (rows[i]) begin
            exec(lw(rows[i].aug, rows[i].lvl), 32'h0, rows[i].priv);
            check({29'h0, res.cc_set, res.trap}, {30'h0, rows[i].trap});
            chk_st(rows[i].lvl, rows[i].st);
        end
        chk_st(7'h00, 4'h0);
        strap_const_enable <= 1'b1;
        chk_st(7'h00, 4'h8);
        exec(lw(`LC_AUG_EI, 7'h40), 32'h0, 1'b1);
        exec(lw(`LC_AUG_EI, 7'h35), 32'h0, 1'b1);
        pulse((128'h1 << 7'h40) | (128'h1 << 7'h35));
        wait_irq();
        check({25'h0, irq_level}, 32'h35);
        @(posedge clock);
        irq_take <= 1'b1;
        @(posedge clock);
        irq_take <= 1'b0;
        repeat (8) @(posedge clock);
        check({31'h0, irq_req}, 32'h0);
        chk_st(7'h40, 4'hb);
        @(posedge clock);
        doubleword_status_mode <= 1'b1;
        exec(lw(`LC_AUG_DAI, 7'h35), 32'h0, 1'b1);
        repeat (8) @(posedge clock);
        check({31'h0, irq_req}, 32'h0);
        exec(lw(`LC_AUG_RI, 7'h05), 32'h0, 1'b1);
        wait_irq();
        check({25'h0, irq_level}, 32'h40);
        for (int i = 0; i < 4; i++) begin
            rsp_cc   <= {i[0], 3'h0};
            rsp_wait <= 4'(3 * i);
            exec({`LC_OP_CTRL, 3'h1, 4'hc + 4'(i), `LC_AUG_CHAN, 16'h0005}, 32'h100, 1'b1);
            check({28'h0, last_cmd.op}, 32'hc + i);
            check({31'h0, cmd_busy}, 32'h1);
            check({16'h0, last_cmd.addr}, 32'h0105);
            check({25'h0, res.cc_set, res.cc, res.trap}, {25'h0, 1'b1, i[0], 5'h0});
        end
        check(ncmd, 4);
        exec({`LC_OP_CTRL, 3'h0, `LC_SUB_ECI, `LC_AUG_CHAN, 16'h0105}, 32'h200, 1'b1);
        check({16'h0, last_cmd.addr}, 32'h0105);
        exec({`LC_OP_CTRL, 3'h0, `LC_SUB_ECI, `LC_AUG_CHAN, 16'h0305}, 32'h0, 1'b1);
        check({30'h0, res.trap}, {30'h0, TRAP_UNDEF});
        exec({`LC_OP_CTRL, 3'h1, `LC_SUB_ECI, 3'h6, 16'h0105}, 32'h0, 1'b1);
        check(ncmd, 5);
        rsp_fault <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            rsp_cc <= j ? `LC_CC_INOP : 4'h1;
            exec({`LC_OP_CTRL, 3'h0, `LC_SUB_CHANNEL_DEACTIVATE_CMD, `LC_AUG_CHAN, 16'h0105}, 32'h0, 1'b1);
            check({30'h0, res.trap}, j ? {30'h0, TRAP_NONE} : {30'h0, TRAP_SYSCHK});
        end
        rsp_fault <= 1'b0;
        exec(lw(`LC_AUG_EI, `LC_REAL_TIME_OPTION_MODULE_LVL), 32'h0, 1'b1);
        exec({`LC_HW_BEI, 16'h0000}, 32'h0, 1'b1);
        check({31'h0, sense_blocked}, 32'h1);
        pulse(128'h1 << `LC_REAL_TIME_OPTION_MODULE_LVL);
        chk_st(`LC_REAL_TIME_OPTION_MODULE_LVL, 4'ha);
        exec({`LC_HW_UEI, 16'h0000}, 32'h0, 1'b1);
        check({31'h0, sense_blocked}, 32'h0);
        pulse(128'h1 << `LC_REAL_TIME_OPTION_MODULE_LVL);
        chk_st(`LC_REAL_TIME_OPTION_MODULE_LVL, 4'hb);
        conclude();
    end
endmodule // level_ctrl_tb
